// ---- common/pprc_pkg.sv ----
// Constants, types and helpers for the power, reset and protection control block.
// Assumes a single 200 MHz clock; device pins arrive synchronous to it.
package pprc_pkg;

    // Timing
    localparam int CLK_PERIOD_NS                = 5;
    localparam int POWER_UP_RESET_TIME_NS       = 1000;
    localparam int POR_CYC                      = (POWER_UP_RESET_TIME_NS + CLK_PERIOD_NS - 1)
                                                  / CLK_PERIOD_NS;
    localparam int WAKE_TO_VALID_OUTPUT_TIME_NS = 25;
    localparam int WAKE_CYC                     = (WAKE_TO_VALID_OUTPUT_TIME_NS / CLK_PERIOD_NS
                                                   < 1) ? 1 :
                                                  WAKE_TO_VALID_OUTPUT_TIME_NS / CLK_PERIOD_NS;
    localparam int POR_CNT_W                    = 8;

    // Sizes
    localparam int NUM_MC     = 8;
    localparam int SIG_BYTES  = 8;
    localparam int ARRAY_IN_W = 19;
    localparam int VERIFY_W   = 19;

    // Array input vector fields
    localparam int AIN_FB_LSB  = 0;
    localparam int AIN_DED_LSB = 8;
    localparam int AIN_PD_BIT  = 16;
    localparam int AIN_CLK_BIT = 17;
    localparam int AIN_OEN_BIT = 18;

    // Verify word fields
    localparam int VER_CFG_LSB  = 0;
    localparam int VER_MODE_LSB = 16;
    localparam int VER_PD_BIT   = 18;

    // Reset values
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] IO_OUT_RESET = 8'hff;
    localparam logic [7:0] IO_OE_RESET  = 8'h00;
    localparam logic [7:0] KEEP_RESET   = 8'h00;

    // Macrocell configuration codes
    localparam logic [1:0] MC_REG_OUT  = 2'h0;
    localparam logic [1:0] MC_COMB_IO  = 2'h1;
    localparam logic [1:0] MC_COMB_OUT = 2'h2;
    localparam logic [1:0] MC_INPUT    = 2'h3;

    // Architecture mode codes; the unused code behaves as simple
    localparam logic [1:0] MODE_REGISTERED = 2'h0;
    localparam logic [1:0] MODE_COMPLEX    = 2'h1;
    localparam logic [1:0] MODE_SIMPLE     = 2'h2;

    typedef enum logic [1:0] {
        ST_POR  = 2'h0,
        ST_RUN  = 2'h1,
        ST_DOWN = 2'h3,
        ST_WAKE = 2'h2
    } pprc_state_t;

    // Effective macrocell role after the architecture mode is applied
    function automatic logic [1:0] pprc_eff_cfg(input logic [1:0] mode, input logic [1:0] cfg);
        logic [1:0] r;
        r = cfg;
        if (mode != MODE_REGISTERED && cfg == MC_REG_OUT) begin
            r = MC_COMB_OUT;
        end else if (mode != MODE_REGISTERED && mode != MODE_COMPLEX && cfg == MC_COMB_IO) begin
            r = MC_COMB_OUT;
        end
        return r;
    endfunction

endpackage

// ---- verilog/pprc_keeper.sv ----
// Pin keepers: each pin holds its last driven level.
// Assumes driven flags mark an external source or the block's own buffer.
`timescale 1ns/1ps
module pprc_keeper
    import pprc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic [7:0] level,
    input  wire logic [7:0] driven,
    output logic      [7:0] held
);

    typedef struct packed {
        logic [7:0] held;
    } pprc_keep_t;

    pprc_keep_t s_q;
    pprc_keep_t s_d;

    // Undriven pins keep their level, also while powered down (see RQ8)
    always_comb begin
        s_d      = s_q;
        s_d.held = (driven & level) | (~driven & s_q.held);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q.held <= KEEP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign held = s_q.held;

endmodule

// ---- verilog/pprc_por_timer.sv ----
// Power-up reset interval timer.
// Assumes resetn models the supply crossing the reset threshold.
`timescale 1ns/1ps
module pprc_por_timer
    import pprc_pkg::*;
(
    input  wire logic clock,
    input  wire logic resetn,
    output logic      done
);

    typedef struct packed {
        logic [POR_CNT_W-1:0] cnt;
        logic                 done;
    } pprc_por_t;

    pprc_por_t s_q;
    pprc_por_t s_d;

    // Counts the whole reset interval (see RQ4)
    always_comb begin
        s_d = s_q;
        if (!s_q.done) begin
            if (s_q.cnt == POR_CNT_W'(POR_CYC - 1)) begin
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + POR_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q.cnt  <= '0;
            s_q.done <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;

endmodule

// ---- verilog/pprc_ctrl.sv ----
// Power-up reset, power-down, macrocell and programmer control of a small PLD.
// Assumes the logic array is outside: it reads array_in, returns sums and OE terms.
// How it works
// (RQ1) Power-up reset clears every macrocell register to low.
// (RQ2) Registered outputs drive inverted, so they show high after power-up reset.
// (RQ3) Board meets setup times before the first clock rise after reset.
// (RQ4) Clock sources stay stable during the power-up reset interval.
// (RQ5) Enabled power-down pin high freezes outputs and internal state; the code still updates the fuse and signature bytes.
// (RQ6) Outputs in high impedance at power-down entry stay high impedance.
// (RQ7) While powered down, clock and inputs are ignored except power-down pin; the code still takes the fuse and signature strobes.
// (RQ8) Undriven input and I/O pins keep their last level, also when down.
// (RQ9) Without the power-down option its pin is an ordinary logic input.
// (RQ10) Preload forces any single macrocell register high or low.
// (RQ11) After the security fuse is set, verify and preload are refused.
// (RQ12) The eight-byte user signature stays readable regardless of the fuse.
// (RQ13) Programmer sets the security fuse last; it acts at once.
// (RQ14) Each macrocell is registered, combinational I/O, combinational out or input.
// (RQ15) One of three architecture modes, by register and OE usage.
// (RQ16) After power-down pin falls, outputs resume within the wake time.
// (RQ17) Leaving power-down resumes from held state without register reset.
`timescale 1ns/1ps
module pprc_ctrl
    import pprc_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  resetn,
    input  wire logic                  dev_clk,
    input  wire logic                  oe_n_pin,
    input  wire logic                  power_down_pin,
    input  wire logic [7:0]            ded_in,
    input  wire logic [7:0]            ded_drv,
    input  wire logic [7:0]            io_in,
    input  wire logic [7:0]            io_ext_drv,
    input  wire logic                  pd_enable,
    input  wire logic [1:0]            arch_mode,
    input  wire logic [15:0]           mc_cfg,
    input  wire logic [7:0]            array_sum,
    input  wire logic [7:0]            array_pt_oe,
    output logic      [ARRAY_IN_W-1:0] array_in,
    output logic      [7:0]            io_out,
    output logic      [7:0]            io_oe,
    input  wire logic                  preload_stb,
    input  wire logic [2:0]            preload_idx,
    input  wire logic                  preload_val,
    output logic                       preload_done,
    output logic                       preload_refused,
    input  wire logic                  verify_stb,
    output logic      [VERIFY_W-1:0]   verify_data,
    output logic                       verify_valid,
    output logic                       verify_refused,
    input  wire logic                  secure_stb,
    output logic                       secured,
    input  wire logic                  sig_wr_stb,
    input  wire logic                  sig_rd_stb,
    input  wire logic [2:0]            sig_addr,
    input  wire logic [7:0]            sig_wdata,
    output logic      [7:0]            sig_rdata,
    output logic                       sig_rvalid,
    output logic                       por_busy,
    output logic                       powered_down
);

    typedef struct packed {
        pprc_state_t                   state;
        logic [7:0]                    regs;
        logic [7:0]                    reg_mask;
        logic                          clk_prev;
        logic [ARRAY_IN_W-1:0]         ain;
        logic [7:0]                    io_out;
        logic [7:0]                    io_oe;
        logic                          secured;
        logic [SIG_BYTES-1:0][7:0]     sig;
        logic [7:0]                    sig_rdata;
        logic                          sig_rvalid;
        logic [VERIFY_W-1:0]           ver_data;
        logic                          ver_valid;
        logic                          ver_refused;
        logic                          pl_done;
        logic                          pl_refused;
        logic                          por_busy;
        logic                          powered_down;
    } pprc_ctrl_t;

    localparam int WAKE_BOUND = WAKE_CYC;

    pprc_ctrl_t s_q;
    pprc_ctrl_t s_d;
    logic       por_done;
    logic [7:0] io_kept;
    logic [7:0] ded_kept;

    pprc_por_timer u_por (
        .clock  (clock),
        .resetn (resetn),
        .done   (por_done)
    );

    // Own buffer counts as a driver for the I/O keepers
    pprc_keeper u_keep_io (
        .clock  (clock),
        .resetn (resetn),
        .level  (s_q.io_oe & s_q.io_out | ~s_q.io_oe & io_in),
        .driven (io_ext_drv | s_q.io_oe),
        .held   (io_kept)
    );

    pprc_keeper u_keep_ded (
        .clock  (clock),
        .resetn (resetn),
        .level  (ded_in),
        .driven (ded_drv),
        .held   (ded_kept)
    );

    always_comb begin
        logic       pd_req;
        logic       eval;
        logic       clk_rise;
        logic       sec_now;
        logic [1:0] ec;
        pd_req   = pd_enable & power_down_pin;
        eval     = 1'b0;
        clk_rise = 1'b0;
        sec_now  = s_q.secured | secure_stb;
        ec       = MC_INPUT;
        s_d             = s_q;
        s_d.pl_done     = 1'b0;
        s_d.pl_refused  = 1'b0;
        s_d.ver_valid   = 1'b0;
        s_d.ver_refused = 1'b0;
        s_d.sig_rvalid  = 1'b0;

        case (s_q.state)
            ST_POR: begin
                // Clock edges are not taken before the interval ends (see RQ4)
                s_d.clk_prev = dev_clk;
                eval         = 1'b1;
                if (por_done) begin
                    s_d.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pd_req) begin
                    s_d.state = ST_DOWN;
                end else begin
                    eval     = 1'b1;
                    clk_rise = dev_clk & ~s_q.clk_prev;
                    s_d.clk_prev = dev_clk;
                end
            end
            ST_DOWN: begin
                // Registers, outputs and array inputs hold; only the pin is watched, but fuse and signature strobes still act (see RQ5) (see RQ6) (see RQ7)
                if (!pd_req) begin
                    s_d.state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // Clock level moved while down is no edge (see RQ16) (see RQ17)
                s_d.clk_prev = dev_clk;
                s_d.state    = pd_req ? ST_DOWN : ST_RUN;
            end
            default: begin
                s_d.state = ST_POR;
            end
        endcase

        if (eval) begin
            s_d.reg_mask = '0;
            for (int i = 0; i < NUM_MC; i++) begin
                ec = pprc_eff_cfg(arch_mode, mc_cfg[2*i +: 2]);  // see (RQ14) (see RQ15)
                s_d.reg_mask[i] = (ec == MC_REG_OUT);
            end
            // Macrocell registers only see the clock pin in registered mode (see RQ3)
            if (clk_rise && arch_mode == MODE_REGISTERED) begin
                s_d.regs = (s_q.regs & ~s_d.reg_mask) | (array_sum & s_d.reg_mask);
            end
            for (int i = 0; i < NUM_MC; i++) begin
                ec = pprc_eff_cfg(arch_mode, mc_cfg[2*i +: 2]);
                case (ec)
                    MC_REG_OUT: begin
                        s_d.io_out[i] = ~s_d.regs[i];  // see (RQ2)
                        s_d.io_oe[i]  = ~oe_n_pin;
                    end
                    MC_COMB_IO: begin
                        s_d.io_out[i] = array_sum[i];
                        s_d.io_oe[i]  = array_pt_oe[i];
                    end
                    MC_COMB_OUT: begin
                        s_d.io_out[i] = array_sum[i];
                        s_d.io_oe[i]  = 1'b1;
                    end
                    default: begin
                        s_d.io_out[i] = 1'b0;
                        s_d.io_oe[i]  = 1'b0;
                    end
                endcase
                s_d.ain[AIN_FB_LSB + i] = s_d.reg_mask[i] ? s_q.regs[i] : io_kept[i];
            end
            s_d.ain[AIN_DED_LSB +: 8] = ded_kept;
            s_d.ain[AIN_PD_BIT]       = pd_enable ? 1'b0 : power_down_pin;  // see (RQ9)
            s_d.ain[AIN_CLK_BIT]      = (arch_mode != MODE_REGISTERED) & dev_clk;
            s_d.ain[AIN_OEN_BIT]      = (arch_mode != MODE_REGISTERED) & oe_n_pin;
        end

        // Programmer side; the fuse takes effect in its own cycle (see RQ13)
        if (s_q.state != ST_DOWN) begin
            if (preload_stb) begin
                if (sec_now) begin
                    s_d.pl_refused = 1'b1;  // see (RQ11)
                end else begin
                    s_d.regs[preload_idx] = preload_val;  // see (RQ10)
                    s_d.pl_done           = 1'b1;
                end
            end
            if (verify_stb) begin
                if (sec_now) begin
                    s_d.ver_refused = 1'b1;  // see (RQ11)
                    s_d.ver_data    = '0;
                end else begin
                    s_d.ver_valid = 1'b1;
                    s_d.ver_data  = '0;
                    s_d.ver_data[VER_CFG_LSB +: 16] = mc_cfg;
                    s_d.ver_data[VER_MODE_LSB +: 2] = arch_mode;
                    s_d.ver_data[VER_PD_BIT]        = pd_enable;
                end
            end
        end
        if (secure_stb) begin
            s_d.secured = 1'b1;
        end
        if (sig_wr_stb) begin
            s_d.sig[sig_addr] = sig_wdata;
        end
        if (sig_rd_stb) begin
            s_d.sig_rdata  = s_q.sig[sig_addr];  // see (RQ12)
            s_d.sig_rvalid = 1'b1;
        end

        s_d.por_busy     = (s_d.state == ST_POR);
        s_d.powered_down = (s_d.state == ST_DOWN);
    end

    // Registers clear on power-up (see RQ1)
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q.state        <= ST_POR;
            s_q.regs         <= REG_RESET;
            s_q.reg_mask     <= '0;
            s_q.clk_prev     <= 1'b0;
            s_q.ain          <= '0;
            s_q.io_out       <= IO_OUT_RESET;
            s_q.io_oe        <= IO_OE_RESET;
            s_q.secured      <= 1'b0;
            s_q.sig          <= '0;
            s_q.sig_rdata    <= '0;
            s_q.sig_rvalid   <= 1'b0;
            s_q.ver_data     <= '0;
            s_q.ver_valid    <= 1'b0;
            s_q.ver_refused  <= 1'b0;
            s_q.pl_done      <= 1'b0;
            s_q.pl_refused   <= 1'b0;
            s_q.por_busy     <= 1'b1;
            s_q.powered_down <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign array_in        = s_q.ain;
    assign io_out          = s_q.io_out;
    assign io_oe           = s_q.io_oe;
    assign preload_done    = s_q.pl_done;
    assign preload_refused = s_q.pl_refused;
    assign verify_data     = s_q.ver_data;
    assign verify_valid    = s_q.ver_valid;
    assign verify_refused  = s_q.ver_refused;
    assign secured         = s_q.secured;
    assign sig_rdata       = s_q.sig_rdata;
    assign sig_rvalid      = s_q.sig_rvalid;
    assign por_busy        = s_q.por_busy;
    assign powered_down    = s_q.powered_down;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_por_regs_low: assert property ( // see (RQ1)
        (s_q.state == ST_POR && !preload_stb && $past(!preload_stb)) |-> s_q.regs == REG_RESET)
        else $error("Registers not low during power-up reset");
    chk_reg_out_high: assert property ( // see (RQ2)
        (s_q.state == ST_POR && $past(s_q.state == ST_POR) && !$past(preload_stb))
        |-> &(s_q.io_out | ~s_q.reg_mask))
        else $error("Registered output not high after power-up reset");
    chk_pd_freeze: assert property ( // see (RQ5)
        (s_q.state == ST_DOWN && $past(s_q.state == ST_DOWN))
        |-> $stable(s_q.io_out) && $stable(s_q.regs) && $stable(s_q.ain))
        else $error("State changed while powered down");
    chk_hiz_kept: assert property ( // see (RQ6)
        (s_q.state == ST_RUN && pd_enable && power_down_pin) ##1 (s_q.state == ST_DOWN)[*3]
        |-> (s_q.io_oe & ~$past(s_q.io_oe, 3)) == 8'h00)
        else $error("High impedance output enabled during power-down");
    chk_pd_entry: assert property ( // see (RQ7)
        (s_q.state == ST_RUN && pd_enable && power_down_pin)
        |=> s_q.state == ST_DOWN && s_q.powered_down && $stable(s_q.regs))
        else $error("Power-down not entered or clock taken");
    chk_plain_pd_input: assert property ( // see (RQ9)
        (s_q.state == ST_RUN && !pd_enable)
        |=> s_q.state == ST_RUN && s_q.ain[AIN_PD_BIT] == $past(power_down_pin))
        else $error("Power-down pin not a plain input");
    chk_wake_bound: assert property ( // see (RQ16)
        (s_q.state == ST_DOWN && !power_down_pin) ##1 !power_down_pin
        |-> ##[0:WAKE_BOUND] s_q.state == ST_RUN)
        else $error("Outputs not resumed in time after power-down");
    chk_resume_held: assert property ( // see (RQ17)
        (s_q.state == ST_WAKE && !preload_stb) |=> s_q.regs == $past(s_q.regs))
        else $error("Registers disturbed on wake");
    chk_preload_force: assert property ( // see (RQ10)
        (preload_stb && !secure_stb && !s_q.secured && s_q.state != ST_DOWN)
        |=> preload_done && s_q.regs[$past(preload_idx)] == $past(preload_val))
        else $error("Preload did not force register");
    chk_secure_refuse: assert property ( // see (RQ11)
        ((s_q.secured || secure_stb) && verify_stb && s_q.state != ST_DOWN)
        |=> verify_refused && !verify_valid && verify_data == '0)
        else $error("Verify not refused after security fuse");
    chk_sig_read: assert property ( // see (RQ12)
        (sig_rd_stb && !sig_wr_stb) ##1 !sig_wr_stb
        |-> sig_rvalid && sig_rdata == s_q.sig[$past(sig_addr)])
        else $error("Signature read failed");
    chk_simple_no_reg: assert property ( // see (RQ15)
        (s_q.state == ST_RUN && !power_down_pin && arch_mode == MODE_SIMPLE)
        |=> s_q.reg_mask == 8'h00)
        else $error("Register used outside registered mode");

    cov_pd_cycle: cover property (
        s_q.state == ST_RUN ##1 s_q.state == ST_DOWN ##[1:20] s_q.state == ST_RUN);
    cov_reg_clock: cover property (s_q.state == ST_RUN && $changed(s_q.regs));
    cov_preload_refused: cover property (preload_refused);
    cov_sig_secured: cover property (sig_rvalid && s_q.secured);

endmodule

// ---- sim/pprc_board_model.sv ----
// Board side model: an external logic array behind the control block.
// Assumes the block's array_in is registered on the same clock.
`timescale 1ns/1ps
module pprc_board_model
    import pprc_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic [ARRAY_IN_W-1:0] array_in,
    output logic      [7:0]            array_sum,
    output logic      [7:0]            array_pt_oe
);
    // Sum terms follow the kept dedicated inputs after one array delay
    always_ff @(posedge clock) begin
        array_sum <= array_in[AIN_DED_LSB +: 8];
    end
    // Product-term enables held off
    assign array_pt_oe = 8'h00;
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the power, reset and protection control block.
// Assumes the board model closes the array loop; all pins driven at falling edge.
`timescale 1ns/1ps
module tb_top
    import pprc_pkg::*;
;
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] cfg;
        logic       oe_n;
        logic [7:0] oe;
    } pprc_row_t;
    logic clock = 0, resetn = 0, dev_clk = 0, oe_n_pin = 0, power_down_pin = 0, pd_enable = 0;
    logic [7:0] ded_in = 8'h00, ded_drv = 8'hff, io_in = 8'h00, io_ext_drv = 8'h00;
    logic [1:0] arch_mode = MODE_REGISTERED;
    logic [15:0] mc_cfg = 16'h0000;
    logic [7:0] array_sum, array_pt_oe, io_out, io_oe, sig_wdata = 8'h00, sig_rdata;
    logic [ARRAY_IN_W-1:0] array_in;
    logic [VERIFY_W-1:0] verify_data;
    logic preload_stb = 0, preload_val = 0, verify_stb = 0, secure_stb = 0;
    logic sig_wr_stb = 0, sig_rd_stb = 0, preload_done, preload_refused, verify_valid;
    logic verify_refused, secured, sig_rvalid, por_busy, powered_down;
    logic [2:0] preload_idx = 3'h0, sig_addr = 3'h0;
    logic [3:0] seen;
    logic rv_seen;
    int bad_count = 0, tests_run = 0, cyc = 0, n;
    pprc_row_t rows [7] = '{
        '{MODE_REGISTERED, MC_INPUT, 1'b0, 8'h00}, '{MODE_REGISTERED, MC_REG_OUT, 1'b0, 8'hff},
        '{MODE_REGISTERED, MC_REG_OUT, 1'b1, 8'h00}, '{MODE_SIMPLE, MC_COMB_OUT, 1'b1, 8'hff},
        '{MODE_COMPLEX, MC_COMB_IO, 1'b0, 8'h00}, '{MODE_SIMPLE, MC_COMB_IO, 1'b0, 8'hff},
        '{MODE_COMPLEX, MC_REG_OUT, 1'b1, 8'hff}};

    always #2.5 clock = ~clock;

    pprc_ctrl u_dut (.clock(clock), .resetn(resetn), .dev_clk(dev_clk), .oe_n_pin(oe_n_pin),
        .power_down_pin(power_down_pin), .ded_in(ded_in), .ded_drv(ded_drv), .io_in(io_in),
        .io_ext_drv(io_ext_drv), .pd_enable(pd_enable), .arch_mode(arch_mode),
        .mc_cfg(mc_cfg), .array_sum(array_sum), .array_pt_oe(array_pt_oe),
        .array_in(array_in), .io_out(io_out), .io_oe(io_oe), .preload_stb(preload_stb),
        .preload_idx(preload_idx), .preload_val(preload_val), .preload_done(preload_done),
        .preload_refused(preload_refused), .verify_stb(verify_stb),
        .verify_data(verify_data), .verify_valid(verify_valid),
        .verify_refused(verify_refused), .secure_stb(secure_stb), .secured(secured),
        .sig_wr_stb(sig_wr_stb), .sig_rd_stb(sig_rd_stb), .sig_addr(sig_addr),
        .sig_wdata(sig_wdata), .sig_rdata(sig_rdata), .sig_rvalid(sig_rvalid),
        .por_busy(por_busy), .powered_down(powered_down));

    pprc_board_model u_board (.clock(clock), .array_in(array_in), .array_sum(array_sum),
        .array_pt_oe(array_pt_oe));

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One programmer strobe: 0 preload, 1 verify, 2 secure, 3 sig write, 4 sig read
    task automatic op(input int k);
        int i;
        seen = 4'h0;
        rv_seen = 1'b0;
        @(negedge clock);
        {sig_rd_stb, sig_wr_stb, secure_stb, verify_stb, preload_stb} = 5'h01 << k;
        @(negedge clock);
        {sig_rd_stb, sig_wr_stb, secure_stb, verify_stb, preload_stb} = 5'h00;
        for (i = 0; i < 4; i++) begin
            seen = seen | {preload_done, preload_refused, verify_valid, verify_refused};
            rv_seen = rv_seen | sig_rvalid;
            @(negedge clock);
        end
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        repeat (5) @(negedge clock);
        check("io_out_rst", io_out, 8'hff);
        check("io_oe_rst", io_oe, 8'h00);
        check("por_busy_rst", por_busy, 1);
        resetn = 1;
        n = 0;
        // Device clock held still through the reset interval
        while (por_busy !== 1'b0 && n < 400) begin
            @(negedge clock);
            n++;
        end
        check("por_len", n >= POR_CYC - 1 && n <= POR_CYC + 2, 1);
        foreach (rows[r]) begin
            arch_mode = rows[r].mode;
            mc_cfg = {8{rows[r].cfg}};
            oe_n_pin = rows[r].oe_n;
            repeat (4) @(negedge clock);
            check("io_oe_row", io_oe, rows[r].oe);
        end
        arch_mode = MODE_REGISTERED;
        mc_cfg = 16'h0000;
        oe_n_pin = 0;
        ded_in = 8'h5a;
        repeat (4) @(negedge clock);
        dev_clk = 1;
        repeat (4) @(negedge clock);
        check("io_out_clk", io_out, 8'ha5);
        // Outputs go high impedance before power-down begins
        oe_n_pin = 1;
        @(negedge clock);
        check("oe_pin_off", io_oe, 8'h00);
        pd_enable = 1;
        power_down_pin = 1;
        repeat (2) @(negedge clock);
        check("pd_on", powered_down, 1);
        ded_in = 8'h0f;
        oe_n_pin = 0;
        dev_clk = 0;
        repeat (3) @(negedge clock);
        dev_clk = 1;
        repeat (4) @(negedge clock);
        check("pd_hold", {io_oe, io_out}, 16'h00a5);
        power_down_pin = 0;
        repeat (WAKE_CYC) @(negedge clock);
        check("pd_wake", {powered_down, io_oe, io_out}, 17'h0ffa5);
        ded_drv = 8'h00;
        ded_in = 8'hc3;
        repeat (3) @(negedge clock);
        check("keeper", array_in[AIN_DED_LSB +: 8], 8'h0f);
        pd_enable = 0;
        power_down_pin = 1;
        repeat (3) @(negedge clock);
        check("pd_plain", {powered_down, array_in[AIN_PD_BIT]}, 2'b01);
        for (int i = 0; i < 8; i++) begin
            preload_idx = i[2:0];
            preload_val = i[0];
            op(0);
            check("preload_pin", io_out[i], !i[0]);
        end
        check("preload_all", io_out, 8'h55);
        op(1);
        check("verify", {seen, verify_data}, {4'h2, pd_enable, arch_mode, mc_cfg});
        sig_addr = 3'h7;
        sig_wdata = 8'h3c;
        op(3);
        // Fuse programmed last
        op(2);
        check("secured", secured, 1);
        op(0);
        check("preload_refuse", {seen, io_out}, {4'h4, 8'h55});
        op(1);
        check("verify_refuse", {seen, verify_data}, {4'h1, 19'h0});
        op(4);
        check("sig_read", sig_rdata, 8'h3c);
        check("sig_rvalid", rv_seen, 1);
        end_sim();
    end
endmodule
